// ===== vsd_regs.svh
// Purpose: Named constants for the VME slave base-address decoder
// Assumes: Included by bare name from the decode and top modules
// Notes: Definitions only
`ifndef VSD_REGS_SVH
`define VSD_REGS_SVH

// Address modifier codes
`define VSD_AM_A24_SUP_BLT 6'h3F
`define VSD_AM_A24_SUP_DAT 6'h3D
`define VSD_AM_A24_SUP_MBLT 6'h3C
`define VSD_AM_A24_USR_BLT 6'h3B
`define VSD_AM_A24_USR_DAT 6'h39
`define VSD_AM_A24_USR_MBLT 6'h38
`define VSD_AM_CFG_SPACE 6'h2F
`define VSD_AM_A32_SUP_BLT 6'h0F
`define VSD_AM_A32_SUP_DAT 6'h0D
`define VSD_AM_A32_SUP_MBLT 6'h0C
`define VSD_AM_A32_USR_BLT 6'h0B
`define VSD_AM_A32_USR_DAT 6'h09
`define VSD_AM_A32_USR_MBLT 6'h08

// Register offsets inside the module's 64 KB window
`define VSD_OFS_BITSET1 16'h1006
`define VSD_OFS_BITCLR1 16'h1008
`define VSD_OFS_BASE_UPPER 16'h1012
`define VSD_OFS_BASE_LOWER 16'h1014

// Field positions and reset values
`define VSD_BIT_BASE_SEL 4
`define VSD_RST_BITSET1 8'h00
`define VSD_RST_BASE_UPPER 8'h00
`define VSD_RST_BASE_LOWER 8'h00

// Address slices
`define VSD_A24_HI 23
`define VSD_A32_HI 31
`define VSD_BASE_LO 16
`define VSD_OFS_HI 15

// Offset steps inside block transfers
`define VSD_STEP_D16 16'h0002
`define VSD_STEP_D32 16'h0004
`define VSD_STEP_D64 16'h0008

`endif

// ===== vsd_pkg.sv
// Purpose: Types shared by the decoder modules
// Assumes: vsd_regs.svh holds the numbers
// Notes: Types only
package vsd_pkg;
    typedef enum logic [1:0] {
        VSD_KIND_SINGLE,
        VSD_KIND_BLT,
        VSD_KIND_MBLT
    } vsd_kind_t;

    typedef enum logic [2:0] {
        VSD_ST_IDLE,
        VSD_ST_DECODE,
        VSD_ST_WAITDS,
        VSD_ST_ACK,
        VSD_ST_SKIP
    } vsd_state_t;
endpackage : vsd_pkg

// ===== vsd_am_decode.sv
// Purpose: Classify an address modifier code
// Assumes: Code is stable in the caller's clock domain
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "vsd_regs.svh"
module vsd_am_decode (
    input wire logic [5:0] am,
    output logic am_ok,
    output logic am_a32,
    output logic am_cfg,
    output vsd_pkg::vsd_kind_t am_kind
);
    import vsd_pkg::*;

    always_comb begin
        am_ok = 1'b1;
        am_a32 = 1'b0;
        am_cfg = 1'b0;
        am_kind = VSD_KIND_SINGLE;
        case (am)
            `VSD_AM_A24_SUP_BLT: am_kind = VSD_KIND_BLT;
            `VSD_AM_A24_SUP_DAT: am_kind = VSD_KIND_SINGLE;
            `VSD_AM_A24_SUP_MBLT: am_kind = VSD_KIND_MBLT;
            `VSD_AM_A24_USR_BLT: am_kind = VSD_KIND_BLT;
            `VSD_AM_A24_USR_DAT: am_kind = VSD_KIND_SINGLE;
            `VSD_AM_A24_USR_MBLT: am_kind = VSD_KIND_MBLT;
            `VSD_AM_CFG_SPACE: am_cfg = 1'b1;
            `VSD_AM_A32_SUP_BLT, `VSD_AM_A32_USR_BLT: begin
                am_a32 = 1'b1;
                am_kind = VSD_KIND_BLT;
            end
            `VSD_AM_A32_SUP_DAT, `VSD_AM_A32_USR_DAT: begin
                am_a32 = 1'b1;
            end
            `VSD_AM_A32_SUP_MBLT, `VSD_AM_A32_USR_MBLT: begin
                am_a32 = 1'b1;
                am_kind = VSD_KIND_MBLT;
            end
            default: am_ok = 1'b0;
        endcase
    end
endmodule : vsd_am_decode
`default_nettype wire

// ===== vsd_top.sv
// Purpose: VME slave base-address decode with base-address registers
// Assumes: VME pins arrive asynchronously; master keeps address valid while AS low
// Notes: DTACK is open-collector, driven low while dtack_oe is high
// Functional notes
// - Accept A24 supervisory BLT, data, MBLT codes
// - Accept A24 user BLT, data, MBLT codes
// - Config-space code marks CR/CSR access
// - Accept A32 supervisory BLT, data, MBLT codes
// - Accept A32 user BLT, data, MBLT codes
// - Decode width set by modifier code
// - Base selectable on 64 KB boundaries
// - Base from rotary switches or registers
// - Select bit 0 means switches; reset value
// - Select bit 1 means programmed registers
// - Upper register A31-24, lower A23-16
// - Single, block and multiplexed block transfers
`timescale 1ns/1ps
`default_nettype none
`include "vsd_regs.svh"
module vsd_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as_n,
    input wire logic vme_ds_n,
    input wire logic vme_write_n,
    input wire logic vme_lword_n,
    input wire logic [31:0] vme_data_in,
    input wire logic [15:0] rotary_sw,
    output logic [31:0] vme_data_out,
    output logic vme_data_oe,
    output logic vme_dtack_n_out,
    output logic vme_dtack_oe,
    output logic acc_strobe,
    output logic [15:0] acc_offset,
    output logic acc_write,
    output vsd_pkg::vsd_kind_t acc_kind,
    output logic acc_a32,
    output logic acc_cfg,
    output logic acc_d32,
    output logic base_sel
);
    import vsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every input except sys_clk and rst_n
    localparam int SW = 32 + 6 + 4 + 32 + 16;
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [31:0] addr_s;
    logic [5:0] am_s;
    logic as_n_s;
    logic ds_n_s;
    logic write_n_s;
    logic lword_n_s;
    logic [31:0] data_s;
    logic [15:0] rot_s;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_ff <= {SW{1'b1}};
            sync2_ff <= {SW{1'b1}};
        end else begin
            sync1_ff <= {vme_addr, vme_am, vme_as_n, vme_ds_n, vme_write_n, vme_lword_n, vme_data_in, rotary_sw};
            sync2_ff <= sync1_ff;
        end
    end

    assign {addr_s, am_s, as_n_s, ds_n_s, write_n_s, lword_n_s, data_s, rot_s} = sync2_ff;

    ////////////////////////////////////////////////////////////////////////
    // Cycle state and latched address phase
    vsd_state_t st_ff, nxt_st;
    logic [31:0] addr_ff, nxt_addr;
    logic [5:0] am_ff, nxt_am;
    logic [7:0] bitset1_ff, nxt_bitset1;
    logic [7:0] upper_ff, nxt_upper;
    logic [7:0] lower_ff, nxt_lower;
    logic [31:0] dout_ff, nxt_dout;
    logic doe_ff, nxt_doe;
    logic dtack_oe_ff, nxt_dtack_oe;
    logic strobe_ff, nxt_strobe;
    logic [15:0] ofs_ff, nxt_ofs;
    logic wr_ff, nxt_wr;
    vsd_kind_t kind_ff, nxt_kind;
    logic a32_ff, nxt_a32;
    logic cfg_ff, nxt_cfg;
    logic d32_ff, nxt_d32;

    logic am_ok;
    logic am_a32;
    logic am_cfg;
    vsd_kind_t am_kind;

    vsd_am_decode u_am (
        .am(am_ff),
        .am_ok(am_ok),
        .am_a32(am_a32),
        .am_cfg(am_cfg),
        .am_kind(am_kind)
    );

    logic [15:0] base_eff;
    logic addr_hit;
    logic [15:0] step;

    always_comb begin
        // Switches give A31-16; registers replace them when selected
        base_eff = bitset1_ff[`VSD_BIT_BASE_SEL] ? {upper_ff, lower_ff} : rot_s;
        // Only the 64 KB page is compared, so bases fall on 64 KB steps
        if (am_a32) begin
            addr_hit = (addr_ff[`VSD_A32_HI:`VSD_BASE_LO] == base_eff);
        end else begin
            addr_hit = (addr_ff[`VSD_A24_HI:`VSD_BASE_LO] == base_eff[7:0]);
        end
        if (kind_ff == VSD_KIND_MBLT) begin
            step = `VSD_STEP_D64;
        end else if (d32_ff) begin
            step = `VSD_STEP_D32;
        end else begin
            step = `VSD_STEP_D16;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_am = am_ff;
        nxt_bitset1 = bitset1_ff;
        nxt_upper = upper_ff;
        nxt_lower = lower_ff;
        nxt_dout = dout_ff;
        nxt_doe = doe_ff;
        nxt_dtack_oe = dtack_oe_ff;
        nxt_strobe = 1'b0;
        nxt_ofs = ofs_ff;
        nxt_wr = wr_ff;
        nxt_kind = kind_ff;
        nxt_a32 = a32_ff;
        nxt_cfg = cfg_ff;
        nxt_d32 = d32_ff;
        case (st_ff)
            VSD_ST_IDLE: begin
                if (!as_n_s) begin
                    nxt_addr = addr_s;
                    nxt_am = am_s;
                    nxt_st = VSD_ST_DECODE;
                end
            end
            VSD_ST_DECODE: begin
                if (am_ok && addr_hit) begin
                    nxt_ofs = addr_ff[`VSD_OFS_HI:0];
                    nxt_kind = am_kind;
                    nxt_a32 = am_a32;
                    nxt_cfg = am_cfg;
                    nxt_st = VSD_ST_WAITDS;
                end else begin
                    // Foreign or unknown cycle: sit out until AS rises
                    nxt_st = VSD_ST_SKIP;
                end
            end
            VSD_ST_WAITDS: begin
                if (as_n_s) begin
                    nxt_st = VSD_ST_IDLE;
                end else if (!ds_n_s) begin
                    nxt_wr = !write_n_s;
                    nxt_d32 = !lword_n_s;
                    nxt_strobe = 1'b1;
                    nxt_dtack_oe = 1'b1;
                    if (!write_n_s) begin
                        case (ofs_ff)
                            `VSD_OFS_BITSET1: nxt_bitset1 = bitset1_ff | data_s[7:0];
                            `VSD_OFS_BITCLR1: nxt_bitset1 = bitset1_ff & ~data_s[7:0];
                            `VSD_OFS_BASE_UPPER: nxt_upper = data_s[7:0];
                            `VSD_OFS_BASE_LOWER: nxt_lower = data_s[7:0];
                            default: nxt_bitset1 = bitset1_ff;
                        endcase
                    end else begin
                        nxt_doe = 1'b1;
                        case (ofs_ff)
                            `VSD_OFS_BITSET1, `VSD_OFS_BITCLR1: nxt_dout = {24'h000000, bitset1_ff};
                            `VSD_OFS_BASE_UPPER: nxt_dout = {24'h000000, upper_ff};
                            `VSD_OFS_BASE_LOWER: nxt_dout = {24'h000000, lower_ff};
                            default: nxt_dout = 32'h00000000;
                        endcase
                    end
                    nxt_st = VSD_ST_ACK;
                end
            end
            VSD_ST_ACK: begin
                if (ds_n_s) begin
                    nxt_dtack_oe = 1'b0;
                    nxt_doe = 1'b0;
                    // Block beats step the offset; single cycles keep it
                    if (kind_ff != VSD_KIND_SINGLE) begin
                        nxt_ofs = 16'(ofs_ff + step);
                    end
                    nxt_st = as_n_s ? VSD_ST_IDLE : VSD_ST_WAITDS;
                end
            end
            VSD_ST_SKIP: begin
                if (as_n_s) begin
                    nxt_st = VSD_ST_IDLE;
                end
            end
            default: nxt_st = VSD_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_ff <= VSD_ST_IDLE;
            addr_ff <= 32'h00000000;
            am_ff <= 6'h00;
            bitset1_ff <= `VSD_RST_BITSET1;
            upper_ff <= `VSD_RST_BASE_UPPER;
            lower_ff <= `VSD_RST_BASE_LOWER;
            dout_ff <= 32'h00000000;
            doe_ff <= 1'b0;
            dtack_oe_ff <= 1'b0;
            strobe_ff <= 1'b0;
            ofs_ff <= 16'h0000;
            wr_ff <= 1'b0;
            kind_ff <= VSD_KIND_SINGLE;
            a32_ff <= 1'b0;
            cfg_ff <= 1'b0;
            d32_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            am_ff <= nxt_am;
            bitset1_ff <= nxt_bitset1;
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            dtack_oe_ff <= nxt_dtack_oe;
            strobe_ff <= nxt_strobe;
            ofs_ff <= nxt_ofs;
            wr_ff <= nxt_wr;
            kind_ff <= nxt_kind;
            a32_ff <= nxt_a32;
            cfg_ff <= nxt_cfg;
            d32_ff <= nxt_d32;
        end
    end

    assign vme_data_out = dout_ff;
    assign vme_data_oe = doe_ff;
    assign vme_dtack_n_out = 1'b0;
    assign vme_dtack_oe = dtack_oe_ff;
    assign acc_strobe = strobe_ff;
    assign acc_offset = ofs_ff;
    assign acc_write = wr_ff;
    assign acc_kind = kind_ff;
    assign acc_a32 = a32_ff;
    assign acc_cfg = cfg_ff;
    assign acc_d32 = d32_ff;
    assign base_sel = bitset1_ff[`VSD_BIT_BASE_SEL];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    base_sel_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |-> !base_sel)
        else $error("base select not zero after reset");
    base_sel_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_WAITDS && !as_n_s && !ds_n_s && !write_n_s && ofs_ff == `VSD_OFS_BITSET1
        && data_s[`VSD_BIT_BASE_SEL]) |=> base_sel)
        else $error("bit set write did not select registers");
    unknown_am_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_DECODE && !am_ok) |=> (st_ff == VSD_ST_SKIP && !vme_dtack_oe))
        else $error("unknown modifier not ignored");
    a24_miss_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_DECODE && am_ok && !am_a32 && addr_ff[`VSD_A24_HI:`VSD_BASE_LO] != base_eff[7:0])
        |=> st_ff == VSD_ST_SKIP)
        else $error("A24 mismatch accepted");
    a32_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_DECODE && am_a32 && addr_ff[`VSD_A32_HI:`VSD_BASE_LO] == base_eff)
        |=> (st_ff == VSD_ST_WAITDS && acc_a32 && acc_offset == addr_ff[`VSD_OFS_HI:0]))
        else $error("A32 match not taken");
    dtack_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_ACK && ds_n_s) |=> (!vme_dtack_oe && !vme_data_oe))
        else $error("DTACK held after data strobe");
    dtack_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(vme_dtack_oe) |-> (acc_strobe && $past(st_ff) == VSD_ST_WAITDS))
        else $error("DTACK without accepted strobe");
    upper_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_WAITDS && !as_n_s && !ds_n_s && write_n_s && ofs_ff == `VSD_OFS_BASE_UPPER)
        |=> (vme_data_oe && vme_data_out[7:0] == $past(upper_ff)))
        else $error("upper base read wrong");
    blt_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff == VSD_ST_ACK && ds_n_s && kind_ff == VSD_KIND_MBLT)
        |=> acc_offset == 16'($past(ofs_ff) + `VSD_STEP_D64))
        else $error("MBLT offset step wrong");
endmodule : vsd_top
`default_nettype wire

// ===== vsd_vme_master.sv
// Purpose: Bus master model driving the slave's VME pins
// Assumes: Calls start and end on a rising edge, one at a time
// Notes: Released lines carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module vsd_vme_master (
    input wire logic sys_clk,
    input wire logic dtack_oe,
    input wire logic [31:0] rd_data,
    output var logic [31:0] addr,
    output var logic [5:0] am,
    output var logic as_n,
    output var logic ds_n,
    output var logic write_n,
    output var logic lword_n,
    output var logic [31:0] wr_data
);
    initial begin
        addr = 32'h0000_0000;
        am = 6'h00;
        as_n = 1'b1;
        ds_n = 1'b1;
        write_n = 1'b1;
        lword_n = 1'b1;
        wr_data = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////
    // Negedge sampling keeps the answer clear of the launch edge
    task automatic wait_dtack(input logic lvl, output logic seen, output logic [31:0] q);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (dtack_oe !== lvl && n < 12);
        seen = (dtack_oe === lvl);
        q = rd_data;
        @(posedge sys_clk);
    endtask : wait_dtack

    task automatic xfer(input logic [5:0] c, input logic [31:0] a, input logic wr, input logic d32,
                        input logic [31:0] wd, input int beats, output logic ok, output logic [31:0] rd);
        logic seen;
        logic [31:0] q;
        ok = 1'b1;
        rd = 32'h0000_0000;
        addr <= a;
        am <= c;
        write_n <= ~wr;
        lword_n <= ~d32;
        wr_data <= wd;
        as_n <= 1'b0;
        // Design needs AS ahead of DS by two cycles
        repeat (2) @(posedge sys_clk);
        for (int b = 0; b < beats && ok; b++) begin
            ds_n <= 1'b0;
            wait_dtack(1'b1, ok, rd);
            ds_n <= 1'b1;
            wait_dtack(1'b0, seen, q);
        end
        as_n <= 1'b1;
        write_n <= wr;
        lword_n <= d32;
        addr <= ~a;
        am <= ~c;
        wr_data <= ~wd;
        repeat (3) @(posedge sys_clk);
    endtask : xfer
endmodule : vsd_vme_master
`default_nettype wire

// ===== vme_slave_base_address_decode_tb.sv
// Purpose: Self-checking bench for the VME base-address decoder
// Assumes: Master model drives every VME pin
// Notes: Accepted beats are recorded at the falling edge
`timescale 1ns/1ps
`default_nettype none
module vme_slave_base_address_decode_tb;
    import vsd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] rotary_sw = 16'hEE12;
    logic [31:0] vme_addr, vme_data_in, vme_data_out, last_ofs;
    logic [5:0] vme_am;
    logic vme_as_n, vme_ds_n, vme_write_n, vme_lword_n, vme_data_oe, vme_dtack_oe, acc_strobe;
    logic acc_write, acc_a32, acc_cfg, acc_d32, base_sel, last_a32, last_cfg, last_d32, last_wr, last_doe;
    logic [15:0] acc_offset;
    vsd_kind_t acc_kind, last_kind;
    int failures = 0;
    int n_checks = 0;
    int n_strobes = 0;
    int cycles = 0;
    logic [5:0] ams [13] = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38, 6'h2F, 6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
    logic [5:0] bad [5] = '{6'h3E, 6'h2D, 6'h29, 6'h00, 6'h0E};

    always #20 sys_clk = ~sys_clk;

    vsd_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .vme_addr(vme_addr), .vme_am(vme_am), .vme_as_n(vme_as_n),
        .vme_ds_n(vme_ds_n), .vme_write_n(vme_write_n), .vme_lword_n(vme_lword_n), .vme_data_in(vme_data_in),
        .rotary_sw(rotary_sw), .vme_data_out(vme_data_out), .vme_data_oe(vme_data_oe), .vme_dtack_n_out(),
        .vme_dtack_oe(vme_dtack_oe), .acc_strobe(acc_strobe), .acc_offset(acc_offset), .acc_write(acc_write),
        .acc_kind(acc_kind), .acc_a32(acc_a32), .acc_cfg(acc_cfg), .acc_d32(acc_d32), .base_sel(base_sel));

    // Undriven data lines show the inverse, so a missing output enable spoils the read
    vsd_vme_master mst (.sys_clk(sys_clk), .dtack_oe(vme_dtack_oe),
        .rd_data(vme_data_oe ? vme_data_out : ~vme_data_out), .addr(vme_addr),
        .am(vme_am), .as_n(vme_as_n), .ds_n(vme_ds_n), .write_n(vme_write_n), .lword_n(vme_lword_n),
        .wr_data(vme_data_in));

    always @(negedge sys_clk) begin
        if (acc_strobe === 1'b1) begin
            last_ofs = {16'h0000, acc_offset};
            last_a32 = acc_a32;
            last_cfg = acc_cfg;
            last_d32 = acc_d32;
            last_kind = acc_kind;
            last_wr = acc_write;
            last_doe = vme_data_oe;
            n_strobes++;
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Hang guard: the whole sequence takes about 580 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : chk

    task automatic acc(input logic [5:0] c, input logic [31:0] a, input logic wr, input logic d32,
                       input logic [31:0] wd, input int beats, input logic exp_ok, input logic [31:0] exp_rd);
        logic ok;
        logic [31:0] rd;
        mst.xfer(c, a, wr, d32, wd, beats, ok, rd);
        chk({31'h0, ok}, {31'h0, exp_ok});
        if (exp_ok) begin
            chk({30'h0, last_wr, last_doe}, {30'h0, wr, !wr});
        end
        if (exp_ok && !wr) begin
            chk(rd, exp_rd);
        end
    endtask : acc

    // A24 codes get junk in A31:24 so the upper byte must be ignored
    function automatic logic [31:0] adr(input logic [5:0] c, input logic [15:0] ofs);
        return {(c[5:4] == 2'b00) ? rotary_sw[15:8] : 8'hA5, rotary_sw[7:0], ofs};
    endfunction : adr

    ////////////////////////////////////////////////////////////////
    initial begin
        int s;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, base_sel}, 32'h0);
        foreach (ams[i]) begin
            acc(ams[i], adr(ams[i], 16'h1012), 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h0);
            chk({31'h0, last_a32}, {31'h0, ams[i][5:4] == 2'b00});
            chk({31'h0, last_cfg}, {31'h0, ams[i] == 6'h2F});
            chk({16'h0, last_ofs[15:0]}, 32'h1012);
            if (ams[i] != 6'h2F) begin
                chk({30'h0, last_kind}, (ams[i][1:0] == 2'b11) ? {30'h0, VSD_KIND_BLT} :
                    (ams[i][1:0] == 2'b00) ? {30'h0, VSD_KIND_MBLT} : {30'h0, VSD_KIND_SINGLE});
            end
        end
        foreach (bad[i]) begin
            acc(bad[i], 32'hEE121012, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        end
        acc(6'h39, 32'h00131012, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        acc(6'h09, 32'hEF121012, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        acc(6'h39, 32'h00121012, 1'b1, 1'b1, 32'h5A, 1, 1'b1, 32'h0);
        acc(6'h39, 32'h00121014, 1'b1, 1'b1, 32'h34, 1, 1'b1, 32'h0);
        acc(6'h3D, 32'h00121012, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h5A);
        acc(6'h09, 32'h5A341012, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        acc(6'h39, 32'h00121006, 1'b1, 1'b1, 32'h10, 1, 1'b1, 32'h0);
        chk({31'h0, base_sel}, 32'h1);
        acc(6'h09, 32'h5A341012, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h5A);
        acc(6'h39, 32'h77341014, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h34);
        acc(6'h39, 32'h00121012, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        acc(6'h09, 32'h5A341008, 1'b1, 1'b1, 32'h10, 1, 1'b1, 32'h0);
        chk({31'h0, base_sel}, 32'h0);
        acc(6'h0D, 32'hEE121014, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h34);
        s = n_strobes;
        acc(6'h3F, 32'h00122000, 1'b0, 1'b1, 32'h0, 3, 1'b1, 32'h0);
        chk(last_ofs, 32'h2008);
        chk(n_strobes - s, 32'h3);
        chk({31'h0, last_d32}, 32'h1);
        acc(6'h0C, 32'hEE122000, 1'b0, 1'b1, 32'h0, 2, 1'b1, 32'h0);
        chk(last_ofs, 32'h2008);
        acc(6'h3B, 32'h00122000, 1'b0, 1'b0, 32'h0, 3, 1'b1, 32'h0);
        chk(last_ofs, 32'h2004);
        chk({31'h0, last_d32}, 32'h0);
        rotary_sw <= 16'hFFFF;
        @(posedge sys_clk);
        acc(6'h0D, 32'hFFFF1012, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h5A);
        acc(6'h3D, 32'h00FF1014, 1'b0, 1'b1, 32'h0, 1, 1'b1, 32'h34);
        acc(6'h3D, 32'h00FE1014, 1'b0, 1'b1, 32'h0, 1, 1'b0, 32'h0);
        end_sim();
    end
endmodule : vme_slave_base_address_decode_tb
`default_nettype wire
